// *** rtl/can_chan_regs.svh ***
// Register offsets, field positions, reset values and limits of the CAN channel block.
// Assumes inclusion by bare name from the design file.
`ifndef CAN_CHAN_REGS_SVH
`define CAN_CHAN_REGS_SVH
`define OFS_CTRL 12'h000
`define OFS_TIMING 12'h004
`define OFS_COMMIT 12'h008
`define OFS_STATUS 12'h00C
`define OFS_ACTIVE 12'h010
`define OFS_CLKBIT 12'h014
`define CTRL_EN_BIT 0
`define CTRL_LISTEN_BIT 1
`define CTRL_SLEEP_BIT 2
`define CTRL_RESET_BIT 3
`define TIM_BRP_LSB 0
`define TIM_PROP_LSB 12
`define TIM_PH1_LSB 16
`define TIM_PH2_LSB 20
`define TIM_SJW_LSB 24
`define CTRL_RESET_VAL 4'h0
`define BRP_RESET_VAL 9'h00A
`define PROP_RESET_VAL 4'h3
`define PH1_RESET_VAL 4'h3
`define PH2_RESET_VAL 4'h3
`define SJW_RESET_VAL 4'h1
`define BRP_MIN 9'h001
`define BRP_MAX 9'h100
`define SEG_MIN 4'h1
`define SEG_MAX 4'h8
`define PH2_MIN 4'h2
`define SJW_MAX 4'h4
`define TSEG1_MIN 5'h04
`define ERR_WARN 9'h060
`define ERR_PASSIVE 9'h080
`define ERR_BUSOFF 9'h100
`define CLK_HZ 100000000
`define RATE_MIN_BPS 5000
`define RATE_MAX_BPS 1000000
`define CLKBIT_MIN (`CLK_HZ / `RATE_MAX_BPS)
`define CLKBIT_MAX (`CLK_HZ / `RATE_MIN_BPS)
`endif

// *** rtl/can_chan_pkg.sv ***
// Types shared by the CAN channel timing and fault state block.
// Assumes the register header supplies all numeric constants.
package can_chan_pkg;
	typedef enum logic [2:0] {
		ST_INACTIVE,
		ST_ACTIVE,
		ST_WARNING,
		ST_PASSIVE,
		ST_BUSOFF
	} chan_state_e;
endpackage : can_chan_pkg

// *** rtl/can_channel_timing_and_fault_state.sv ***
// CAN channel configuration and fault state tracking behind an AHB-Lite slave.
// Assumes a single 100 MHz clock, synchronous reset and a CAN core driven by the outputs.
// Notes on behaviour
// RULE1 - Enabled, count below 96: error active.
// RULE2 - Count reaching 96 reports error warning.
// RULE3 - Count reaching 128 reports error passive.
// RULE4 - Count above 255: controller off, bus off.
// RULE5 - Disabled or sleeping channel reports inactive.
// RULE6 - Listen-only: no transmit, no acknowledge.
// RULE7 - Reset command reinitialises the channel.
// RULE8 - Enable control activates or deactivates channel.
// RULE9 - Prescaler accepts 1 through 256.
// RULE10 - Phase segment one is 1 to 8.
// RULE11 - Phase segment two is 2 to 8.
// RULE12 - Propagation segment is 1 to 8.
// RULE13 - Sync segment fixed at one quantum.
// RULE14 - Segment one is prop plus phase one, at least 4.
// RULE15 - Segment two equals phase segment two.
// RULE16 - Sample point between segment one and two.
// RULE17 - Refuse invalid values or rate outside 5k..1M.
// RULE18 - Jump width bounds resync, not bit rate.
// RULE19 - Jump width accepts 1 through 4.
// RULE20 - Rate is clock over prescaler times quanta.
// RULE21 - Most severe error state wins.
//
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "can_chan_regs.svh"
module can_channel_timing_and_fault_state (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic hreadyout_out,
	output logic hresp_out,
	output logic [31:0] hrdata_out,
	input wire logic bus_err_in,
	input wire logic frame_ok_in,
	output can_chan_pkg::chan_state_e state_out,
	output logic ctrl_on_out,
	output logic tx_enable_out,
	output logic ack_enable_out,
	output logic chan_reset_out,
	output logic [8:0] brp_out,
	output logic [4:0] tseg1_out,
	output logic [3:0] tseg2_out,
	output logic [3:0] sjw_out,
	output logic [4:0] sample_tq_out
);
	logic [3:0] ctrl_r;
	logic [8:0] brp_s_r;
	logic [3:0] prop_s_r;
	logic [3:0] ph1_s_r;
	logic [3:0] ph2_s_r;
	logic [3:0] sjw_s_r;
	logic [8:0] brp_r;
	logic [4:0] tseg1_r;
	logic [3:0] tseg2_r;
	logic [3:0] sjw_r;
	logic [13:0] clkbit_r;
	logic reject_r;
	logic [8:0] err_cnt_r;
	logic busoff_r;
	can_chan_pkg::chan_state_e state_r;
	logic wr_pend_r;
	logic [11:0] wr_addr_r;
	logic [31:0] rdata_r;
	logic addr_ok;
	logic [4:0] tseg1_s;
	logic [4:0] qpb_s;
	logic [13:0] clkbit_s;
	logic cfg_valid;
	logic reset_cmd;
	logic commit_cmd;
	logic active;
	can_chan_pkg::chan_state_e state_nxt;

	// Address phase is taken when the slave is selected, htrans_in marks a NONSEQ or SEQ transfer and the bus is ready.
	assign addr_ok = hsel_in && htrans_in[1] && hready_in;

	// Data phase write strobes for the command registers.
	assign reset_cmd = wr_pend_r && (wr_addr_r == `OFS_CTRL) && hwdata_in[`CTRL_RESET_BIT];
	assign commit_cmd = wr_pend_r && (wr_addr_r == `OFS_COMMIT) && hwdata_in[0];

	// Staged timing arithmetic; the jump width takes no part in the rate.
	assign tseg1_s = {1'b0, prop_s_r} + {1'b0, ph1_s_r}; // RULE14
	assign qpb_s = 5'h01 + tseg1_s + {1'b0, ph2_s_r}; // RULE13 RULE15 RULE18
	assign clkbit_s = 14'(brp_s_r) * 14'(qpb_s); // RULE20

	// Every staged field is range checked and the bit rate bounded.
	always_comb begin
		cfg_valid = 1'b1;
		if (brp_s_r < `BRP_MIN || brp_s_r > `BRP_MAX) begin // RULE9
			cfg_valid = 1'b0;
		end
		if (ph1_s_r < `SEG_MIN || ph1_s_r > `SEG_MAX) begin // RULE10
			cfg_valid = 1'b0;
		end
		if (ph2_s_r < `PH2_MIN || ph2_s_r > `SEG_MAX) begin // RULE11
			cfg_valid = 1'b0;
		end
		if (prop_s_r < `SEG_MIN || prop_s_r > `SEG_MAX) begin // RULE12
			cfg_valid = 1'b0;
		end
		if (tseg1_s < `TSEG1_MIN) begin // RULE14
			cfg_valid = 1'b0;
		end
		if (sjw_s_r < `SEG_MIN || sjw_s_r > `SJW_MAX) begin // RULE19
			cfg_valid = 1'b0;
		end
		// The upper limit does not fit in 14 bits, so both bounds are compared at full word width.
		if ({18'h00000, clkbit_s} < 32'(`CLKBIT_MIN) || {18'h00000, clkbit_s} > 32'(`CLKBIT_MAX)) begin // RULE17
			cfg_valid = 1'b0;
		end
	end

	// Bus handshake: zero wait states, always an OKAY answer.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end else begin
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end
	end

	// Write address is held from address phase to data phase.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 12'h000;
		end else begin
			wr_pend_r <= addr_ok && hwrite_in;
			wr_addr_r <= haddr_in[11:0];
		end
	end

	// Read data is prepared during the address phase; unmapped words read zero.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rdata_r <= 32'h00000000;
		end else if (addr_ok && !hwrite_in) begin
			if (haddr_in[31:12] != 20'h00000) begin
				rdata_r <= 32'h00000000;
			end else if (haddr_in[11:0] == `OFS_CTRL) begin
				rdata_r <= {29'h00000000, ctrl_r[2:0]};
			end else if (haddr_in[11:0] == `OFS_TIMING) begin
				rdata_r <= {4'h0, sjw_s_r, ph2_s_r, ph1_s_r, prop_s_r, 3'h0, brp_s_r};
			end else if (haddr_in[11:0] == `OFS_STATUS) begin
				rdata_r <= {14'h0000, reject_r, busoff_r, 4'h0, state_r, err_cnt_r};
			end else if (haddr_in[11:0] == `OFS_ACTIVE) begin
				rdata_r <= {4'h0, sjw_r, tseg2_r, 3'h0, tseg1_r, 3'h0, brp_r};
			end else if (haddr_in[11:0] == `OFS_CLKBIT) begin
				rdata_r <= {18'h00000, clkbit_r};
			end else begin
				rdata_r <= 32'h00000000;
			end
		end
	end
	assign hrdata_out = rdata_r;

	// Control bits: enable, listen-only and sleep; reset is a self-clearing pulse.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			ctrl_r <= `CTRL_RESET_VAL;
		end else if (wr_pend_r && wr_addr_r == `OFS_CTRL) begin
			ctrl_r <= {1'b0, hwdata_in[2:0]}; // RULE8
		end
	end

	// Staged timing values written by software.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			brp_s_r <= `BRP_RESET_VAL;
			prop_s_r <= `PROP_RESET_VAL;
			ph1_s_r <= `PH1_RESET_VAL;
			ph2_s_r <= `PH2_RESET_VAL;
			sjw_s_r <= `SJW_RESET_VAL;
		end else if (wr_pend_r && wr_addr_r == `OFS_TIMING) begin
			brp_s_r <= hwdata_in[`TIM_BRP_LSB +: 9];
			prop_s_r <= hwdata_in[`TIM_PROP_LSB +: 4];
			ph1_s_r <= hwdata_in[`TIM_PH1_LSB +: 4];
			ph2_s_r <= hwdata_in[`TIM_PH2_LSB +: 4];
			sjw_s_r <= hwdata_in[`TIM_SJW_LSB +: 4];
		end
	end

	// A commit loads the active timing only when valid, else flags a refusal.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			brp_r <= `BRP_RESET_VAL;
			tseg1_r <= {1'b0, `PROP_RESET_VAL} + {1'b0, `PH1_RESET_VAL};
			tseg2_r <= `PH2_RESET_VAL;
			sjw_r <= `SJW_RESET_VAL;
			clkbit_r <= 14'h0064;
			reject_r <= 1'b0;
		end else if (commit_cmd) begin
			if (cfg_valid) begin
				brp_r <= brp_s_r;
				tseg1_r <= tseg1_s; // RULE14
				tseg2_r <= ph2_s_r; // RULE15
				sjw_r <= sjw_s_r; // RULE18
				clkbit_r <= clkbit_s; // RULE20
				reject_r <= 1'b0;
			end else begin
				reject_r <= 1'b1; // RULE17
			end
		end
	end

	// Channel takes part in the bus only when enabled and awake.
	assign active = ctrl_r[`CTRL_EN_BIT] && !ctrl_r[`CTRL_SLEEP_BIT];

	// Error counter saturates at the bus-off level; bus off holds until a reset.
	always_ff @(posedge clk_in) begin
		if (reset_in || reset_cmd) begin
			err_cnt_r <= 9'h000; // RULE7
			busoff_r <= 1'b0;
		end else begin
			if (active && !busoff_r) begin
				if (bus_err_in && !frame_ok_in && err_cnt_r != `ERR_BUSOFF) begin
					err_cnt_r <= err_cnt_r + 9'h001;
				end else if (frame_ok_in && !bus_err_in && err_cnt_r != 9'h000) begin
					err_cnt_r <= err_cnt_r - 9'h001;
				end
			end
			if (err_cnt_r >= `ERR_BUSOFF) begin
				busoff_r <= 1'b1; // RULE4
			end
		end
	end

	// Reported state, most severe first.
	always_comb begin
		if (!active) begin
			state_nxt = can_chan_pkg::ST_INACTIVE; // RULE5
		end else if (busoff_r || err_cnt_r >= `ERR_BUSOFF) begin
			state_nxt = can_chan_pkg::ST_BUSOFF; // RULE4 RULE21
		end else if (err_cnt_r >= `ERR_PASSIVE) begin
			state_nxt = can_chan_pkg::ST_PASSIVE; // RULE3
		end else if (err_cnt_r >= `ERR_WARN) begin
			state_nxt = can_chan_pkg::ST_WARNING; // RULE2
		end else begin
			state_nxt = can_chan_pkg::ST_ACTIVE; // RULE1
		end
	end

	// State register and bus-side enables.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state_r <= can_chan_pkg::ST_INACTIVE;
			ctrl_on_out <= 1'b0;
			tx_enable_out <= 1'b0;
			ack_enable_out <= 1'b0;
			chan_reset_out <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ctrl_on_out <= active && !busoff_r && !reset_cmd; // RULE4 RULE8
			tx_enable_out <= active && !busoff_r && !reset_cmd && !ctrl_r[`CTRL_LISTEN_BIT]; // RULE6
			ack_enable_out <= active && !busoff_r && !reset_cmd && !ctrl_r[`CTRL_LISTEN_BIT]; // RULE6
			chan_reset_out <= reset_cmd; // RULE7
		end
	end
	assign state_out = state_r;

	// Timing outputs to the bit timing logic; the sample point follows segment one.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			brp_out <= `BRP_RESET_VAL;
			tseg1_out <= 5'h06;
			tseg2_out <= `PH2_RESET_VAL;
			sjw_out <= `SJW_RESET_VAL;
			sample_tq_out <= 5'h07;
		end else begin
			brp_out <= brp_r;
			tseg1_out <= tseg1_r;
			tseg2_out <= tseg2_r;
			sjw_out <= sjw_r;
			sample_tq_out <= 5'h01 + tseg1_r; // RULE13 RULE16
		end
	end

	sequence s_commit_bad;
		commit_cmd && !cfg_valid;
	endsequence
	sequence s_refused;
		##1 reject_r && $stable(brp_r) && $stable(tseg1_r);
	endsequence
	property p_refuse;
		@(posedge clk_in) disable iff (reset_in) s_commit_bad |-> s_refused;
	endproperty
	a_refuse: assert property (p_refuse) else $error("Bad timing was taken."); // RULE17
	property p_brp_range;
		@(posedge clk_in) disable iff (reset_in) brp_r >= `BRP_MIN && brp_r <= `BRP_MAX;
	endproperty
	a_brp_range: assert property (p_brp_range) else $error("Prescaler out of range."); // RULE9
	property p_seg_range;
		@(posedge clk_in) disable iff (reset_in)
			tseg1_r >= `TSEG1_MIN && tseg2_r >= `PH2_MIN && tseg2_r <= `SEG_MAX;
	endproperty
	a_seg_range: assert property (p_seg_range) else $error("Segment out of range."); // RULE14
	property p_sjw_range;
		@(posedge clk_in) disable iff (reset_in) sjw_r >= `SEG_MIN && sjw_r <= `SJW_MAX;
	endproperty
	a_sjw_range: assert property (p_sjw_range) else $error("Jump width out of range."); // RULE19
	property p_warn;
		@(posedge clk_in) disable iff (reset_in)
			active && !busoff_r && err_cnt_r >= `ERR_WARN && err_cnt_r < `ERR_PASSIVE
			|=> state_out == can_chan_pkg::ST_WARNING;
	endproperty
	a_warn: assert property (p_warn) else $error("Warning state missed."); // RULE2
	property p_busoff;
		@(posedge clk_in) disable iff (reset_in)
			active && err_cnt_r == `ERR_BUSOFF && !reset_cmd |=> ##1 !ctrl_on_out && !tx_enable_out;
	endproperty
	a_busoff: assert property (p_busoff) else $error("Controller still on at bus off."); // RULE4
	property p_inactive;
		@(posedge clk_in) disable iff (reset_in) !active |=> state_out == can_chan_pkg::ST_INACTIVE;
	endproperty
	a_inactive: assert property (p_inactive) else $error("Idle channel shows an error state."); // RULE5
	property p_listen;
		@(posedge clk_in) disable iff (reset_in) ctrl_r[`CTRL_LISTEN_BIT] |=> !tx_enable_out && !ack_enable_out;
	endproperty
	a_listen: assert property (p_listen) else $error("Listen-only channel drives the bus."); // RULE6
	property p_reset_cmd;
		@(posedge clk_in) disable iff (reset_in) reset_cmd |=> chan_reset_out && err_cnt_r == 9'h000;
	endproperty
	a_reset_cmd: assert property (p_reset_cmd) else $error("Channel reset not applied."); // RULE7
	property p_sample;
		@(posedge clk_in) disable iff (reset_in) ##1 sample_tq_out == 5'h01 + $past(tseg1_r);
	endproperty
	a_sample: assert property (p_sample) else $error("Sample point misplaced."); // RULE16
	property p_active;
		@(posedge clk_in) disable iff (reset_in)
			active && !busoff_r && err_cnt_r < `ERR_WARN |=> state_out == can_chan_pkg::ST_ACTIVE;
	endproperty
	a_active: assert property (p_active) else $error("Error active state missed."); // RULE1
	property p_passive;
		@(posedge clk_in) disable iff (reset_in)
			active && !busoff_r && err_cnt_r >= `ERR_PASSIVE && err_cnt_r < `ERR_BUSOFF
			|=> state_out == can_chan_pkg::ST_PASSIVE;
	endproperty
	a_passive: assert property (p_passive) else $error("Error passive state missed."); // RULE3
endmodule : can_channel_timing_and_fault_state

// *** tb/can_far_nodes.sv ***
// Behavioural model of the other nodes on the CAN bus, reduced to error and good-frame events.
// Assumes the bench calls send() hierarchically and that the channel counts one event per pulse.
`timescale 1ns/1ps
module can_far_nodes (
	input wire logic clk_in,
	output logic bus_err_out,
	output logic frame_ok_out
);
	// Both event lines idle low until the bench asks for traffic.
	initial begin
		bus_err_out = 1'b0;
		frame_ok_out = 1'b0;
	end

	// Emits n event pulses, back to back or with idle cycles between them to model a slow bus.
	task automatic send(input logic e, input logic f, input int n, input int gap);
		repeat (n) begin
			@(posedge clk_in);
			bus_err_out <= e;
			frame_ok_out <= f;
			repeat (gap) begin
				@(posedge clk_in);
				bus_err_out <= 1'b0;
				frame_ok_out <= 1'b0;
			end
		end
		@(posedge clk_in);
		bus_err_out <= 1'b0;
		frame_ok_out <= 1'b0;
	endtask : send
endmodule : can_far_nodes

// *** tb/can_channel_timing_and_fault_state_test.sv ***
// Self-checking bench for the CAN channel timing and fault state block.
// Assumes a single 100 MHz clock, an AHB-Lite master in this bench and the far-node model.
`timescale 1ns/1ps
`include "can_chan_regs.svh"
module can_channel_timing_and_fault_state_test;
	logic clk_in, reset_in, hsel, hwrite, hreadyout, hresp, err_p, ok_p;
	logic ctrl_on, tx_en, ack_en, chan_rst, bo, rej;
	logic [31:0] haddr, hwdata, rd, w, ctl;
	logic [1:0] htrans;
	logic [8:0] brp, cnt, eb;
	logic [4:0] tseg1, sample, e1;
	logic [3:0] tseg2, sjw, e2, ej;
	can_chan_pkg::chan_state_e state;
	int fails, num_checks, pulses, prev;
	logic [31:0] tab [16] = '{32'h84231014, 32'h8133300A, 32'h01231001, 32'h81888100, 32'h01333000,
		32'h01333101, 32'h01340014, 32'h01319014, 32'h01392014, 32'h01133014, 32'h01933014,
		32'h00333014, 32'h05333014, 32'h01321014, 32'h84333014, 32'h01333009};
	int tgt [7] = '{95, 96, 127, 128, 255, 256, 300};

	can_channel_timing_and_fault_state can_channel_timing_and_fault_state_inst (.clk_in(clk_in),
		.reset_in(reset_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hreadyout), .hreadyout_out(hreadyout),
		.hresp_out(hresp), .hrdata_out(rd), .bus_err_in(err_p), .frame_ok_in(ok_p), .state_out(state),
		.ctrl_on_out(ctrl_on), .tx_enable_out(tx_en), .ack_enable_out(ack_en),
		.chan_reset_out(chan_rst), .brp_out(brp), .tseg1_out(tseg1), .tseg2_out(tseg2),
		.sjw_out(sjw), .sample_tq_out(sample));
	can_far_nodes can_far_nodes_inst (.clk_in(clk_in), .bus_err_out(err_p), .frame_ok_out(ok_p));

	// Clock generation.
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// Counts the cycles in which the channel reset pulse stands.
	always @(posedge clk_in) begin
		if (chan_rst === 1'b1) pulses <= pulses + 1;
	end

	// Compares one value and reports a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One AHB-Lite single word transfer; read data is taken at the edge ending the data phase.
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_in);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk_in); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_in); while (hreadyout !== 1'b1);
		q = rd;
	endtask : bus

	// Reads STATUS and compares it, the state output and the controller-on flag with the model.
	task automatic status_chk();
		logic [2:0] es;
		logic [31:0] q;
		es = bo ? can_chan_pkg::ST_BUSOFF : cnt >= 9'h080 ? can_chan_pkg::ST_PASSIVE :
			cnt >= 9'h060 ? can_chan_pkg::ST_WARNING : can_chan_pkg::ST_ACTIVE;
		if (ctl[0] !== 1'b1 || ctl[2] !== 1'b0) es = can_chan_pkg::ST_INACTIVE;
		bus(1'b0, `OFS_STATUS, 32'h0, q);
		chk(q, {14'h0, rej, bo, 4'h0, es, cnt});
		chk({29'h0, state}, {29'h0, es});
		chk({31'h0, ctrl_on}, {31'h0, es != can_chan_pkg::ST_INACTIVE && !bo});
	endtask : status_chk

	// Prints the counts and the verdict, then ends the run.
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_sim

	// Watchdog sized well above the expected run of under a thousand cycles.
	initial begin
		repeat (20000) @(posedge clk_in);
		fails++;
		end_sim();
	end

	// Main test sequence.
	initial begin
		reset_in = 1'b1;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		{fails, num_checks, pulses} = '0;
		{cnt, bo, rej, w, ctl} = '0;
		{eb, e1, e2, ej} = {9'h00A, 5'h06, 4'h3, 4'h1};
		repeat (10) @(posedge clk_in);
		reset_in <= 1'b0;
		status_chk();
		for (int i = 0; i < 16; i++) begin
			bus(1'b1, `OFS_TIMING, {1'b0, tab[i][30:0]}, w);
			bus(1'b0, `OFS_TIMING, 32'h0, w);
			chk(w, {1'b0, tab[i][30:0]});
			if (i > 0) bus(1'b1, `OFS_COMMIT, 32'h1, w);
			if (i > 0 && tab[i][31]) {ej, e2, e1, eb} = {tab[i][27:20], 5'(tab[i][15:12]) + 5'(tab[i][19:16]), tab[i][8:0]};
			if (i > 0) rej = !tab[i][31];
			bus(1'b0, `OFS_STATUS, 32'h0, w);
			chk({31'h0, w[17]}, {31'h0, rej});
			chk({5'h0, brp, tseg1, tseg2, sjw, sample}, {5'h0, eb, e1, e2, ej, e1 + 5'h1});
			bus(1'b0, `OFS_CLKBIT, 32'h0, w);
			chk(w, 32'(eb) * (32'h1 + 32'(e1) + 32'(e2)));
		end
		bus(1'b0, `OFS_ACTIVE, 32'h0, w);
		chk(w, {4'h0, ej, e2, 3'h0, e1, 3'h0, eb});
		$display("test timing done");
		bus(1'b1, `OFS_CTRL, 32'h1, w);
		ctl = 32'h1;
		status_chk();
		prev = 0;
		for (int i = 0; i < 7; i++) begin
			can_far_nodes_inst.send(1'b1, 1'b0, tgt[i] - prev, i % 2);
			prev = tgt[i];
			cnt = (tgt[i] > 256) ? 9'h100 : 9'(tgt[i]);
			bo = tgt[i] >= 256;
			repeat (2) @(posedge clk_in);
			status_chk();
		end
		bus(1'b1, `OFS_CTRL, 32'h9, w);
		{cnt, bo} = '0;
		ctl = 32'h1;
		repeat (2) @(posedge clk_in);
		chk(pulses, 32'h1);
		status_chk();
		can_far_nodes_inst.send(1'b1, 1'b0, 96, 0);
		can_far_nodes_inst.send(1'b0, 1'b1, 1, 0);
		can_far_nodes_inst.send(1'b1, 1'b1, 3, 0);
		cnt = 9'h05F;
		repeat (2) @(posedge clk_in);
		status_chk();
		$display("test error states done");
		bus(1'b1, `OFS_CTRL, 32'h3, w);
		ctl = 32'h3;
		repeat (2) @(posedge clk_in);
		chk({30'h0, tx_en, ack_en}, 32'h0);
		status_chk();
		bus(1'b1, `OFS_CTRL, 32'h1, w);
		ctl = 32'h1;
		repeat (2) @(posedge clk_in);
		chk({30'h0, tx_en, ack_en}, 32'h3);
		bus(1'b1, `OFS_CTRL, 32'h5, w);
		ctl = 32'h5;
		can_far_nodes_inst.send(1'b1, 1'b0, 5, 0);
		repeat (2) @(posedge clk_in);
		status_chk();
		bus(1'b1, `OFS_CTRL, 32'h0, w);
		ctl = 32'h0;
		status_chk();
		bus(1'b0, `OFS_CTRL, 32'h0, w);
		chk(w, 32'h0);
		bus(1'b1, 12'h020, 32'hFFFFFFFF, w);
		bus(1'b0, 12'h020, 32'h0, w);
		chk(w, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		$display("test modes done");
		end_sim();
	end
endmodule : can_channel_timing_and_fault_state_test
